// [verilog/pin_select_map.svh]
// Register offsets, field positions, codes and reset values of the input source selection block.
`ifndef PIN_SELECT_MAP_SVH
`define PIN_SELECT_MAP_SVH

`define OFS_INPUT_SELECT_HALL    4'h0
`define OFS_INPUT_SELECT_SERIAL  4'h4
`define OFS_INPUT_SELECT_CAPTURE 4'h8
`define OFS_ROUTE_STATUS         4'hC

`define RST_INPUT_SELECT_HALL    8'h00
`define RST_INPUT_SELECT_SERIAL  8'h00
`define RST_INPUT_SELECT_CAPTURE 8'h00

`define POS_HALL_SRC_FIELD       2
`define POS_CAP0_SRC_FIELD       6
`define POS_CAP1_SRC_FIELD       4
`define POS_CAPTURE_RESERVED     2
`define POS_CAP3_SRC_FIELD       0

`define CODE_SRC_PRIMARY         2'h0
`define CODE_SRC_ALIAS           2'h3

`define INACTIVE_LEVEL           1'b0

`define RESP_OKAY                2'h0
`define RESP_SLVERR              2'h2

`endif

// [verilog/pin_select_pkg.sv]
// Types and shared decode functions of the input source selection block.
package pin_select_pkg;

   typedef struct packed {
      logic port_b_bit1;
      logic port_a_bit2;
      logic port_a_bit0;
      logic port_a_bit3;
   } port_pins_t;

   typedef struct packed {
      logic timer3_capture_in;
      logic timer1_capture_in;
      logic timer0_capture_in;
      logic hall_sensor_input_one;
   } peripheral_in_t;

   // A field selects its pin on code 00, and on code 11 where that code is an alias.
   function automatic logic src_selected(input logic [1:0] field, input logic alias_ok);
      src_selected = (field == 2'h0) || (alias_ok && (field == 2'h3));
   endfunction

   // Byte-lane merge of one eight-bit register from a 32-bit write.
   function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
      merge_byte = strb[0] ? data[7:0] : old;
   endfunction

endpackage

// [verilog/select_reg.sv]
// One eight-bit software selection register written through byte lane zero.
module select_reg
   import pin_select_pkg::*;
#(
   parameter logic [7:0] RESET_VALUE = 8'h00
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // Write port
   input  wire logic        wr_en,
   input  wire logic [31:0] wr_data,
   input  wire logic [3:0]  wr_strb,
   // Stored value
   output logic      [7:0]  value
);

   logic [7:0] next_value;

   always_comb begin
      next_value = value;
      if (wr_en) begin
         next_value = merge_byte(value, wr_data, wr_strb);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         value <= 8'h00 | RESET_VALUE;
      end else if (ce) begin
         value <= next_value;
      end
   end

endmodule

// [verilog/src_route.sv]
// Routes one port pin to one peripheral input, or parks the input when the code is reserved.
`include "pin_select_map.svh"

module src_route
   import pin_select_pkg::*;
#(
   parameter logic ALIAS_OK = 1'b1
) (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       ce,
   // Selection and source
   input  wire logic [1:0] field,
   input  wire logic       pin,
   // Peripheral input
   output logic            routed
);

   logic next_routed;

   always_comb begin
      if (src_selected(field, ALIAS_OK)) begin
         next_routed = pin;
      end else begin
         next_routed = `INACTIVE_LEVEL;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         routed <= `INACTIVE_LEVEL;
      end else if (ce) begin
         routed <= next_routed;
      end
   end

endmodule

// [verilog/input_source_pin_select.sv]
// Top of the input source selection block with its AXI4-Lite register slave.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`include "pin_select_map.svh"

// Notes on behaviour
// - Port A bit 3 feeds the hall input when the hall field is 00 or 11.
// - Port A bit 0 feeds timer 0 capture when capture bits 7:6 are 00 or 11.
// - Port A bit 2 feeds timer 1 capture only when capture bits 5:4 are 00.
// - Port B bit 1 feeds timer 3 capture when capture bits 1:0 are 00 or 11.
module input_source_pin_select
   import pin_select_pkg::*;
(
   // Clock, reset and clock enable
   input  wire logic           aclk,
   input  wire logic           aresetn,
   input  wire logic           ce,
   // AXI4-Lite write address and data
   input  wire logic [3:0]     s_awaddr,
   input  wire logic           s_awvalid,
   output logic                s_awready,
   input  wire logic [31:0]    s_wdata,
   input  wire logic [3:0]     s_wstrb,
   input  wire logic           s_wvalid,
   output logic                s_wready,
   // AXI4-Lite write response
   output logic [1:0]          s_bresp,
   output logic                s_bvalid,
   input  wire logic           s_bready,
   // AXI4-Lite read
   input  wire logic [3:0]     s_araddr,
   input  wire logic           s_arvalid,
   output logic                s_arready,
   output logic [31:0]         s_rdata,
   output logic [1:0]          s_rresp,
   output logic                s_rvalid,
   input  wire logic           s_rready,
   // Port pins and routed peripheral inputs
   input  wire port_pins_t     pins,
   output peripheral_in_t      periph
);

   logic [7:0]  input_select_hall;
   logic [7:0]  input_select_serial;
   logic [7:0]  input_select_capture;

   logic        aw_held;
   logic        w_held;
   logic [3:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;

   logic        next_aw_held;
   logic        next_w_held;
   logic [3:0]  next_aw_addr;
   logic [31:0] next_w_data;
   logic [3:0]  next_w_strb;
   logic        next_awready;
   logic        next_wready;
   logic        next_bvalid;
   logic [1:0]  next_bresp;
   logic        next_arready;
   logic        next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;

   logic        do_write;
   logic        wr_hall;
   logic        wr_serial;
   logic        wr_capture;

   // An address is mapped when it hits one of the four words.
   function automatic logic addr_mapped(input logic [3:0] addr);
      addr_mapped = (addr == `OFS_INPUT_SELECT_HALL) || (addr == `OFS_INPUT_SELECT_SERIAL) ||
                    (addr == `OFS_INPUT_SELECT_CAPTURE) || (addr == `OFS_ROUTE_STATUS);
   endfunction

   // A write commits once both address and data are held and no response is pending.
   assign do_write   = aw_held && w_held && !s_bvalid;
   assign wr_hall    = do_write && (aw_addr == `OFS_INPUT_SELECT_HALL);
   assign wr_serial  = do_write && (aw_addr == `OFS_INPUT_SELECT_SERIAL);
   assign wr_capture = do_write && (aw_addr == `OFS_INPUT_SELECT_CAPTURE);

   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_bvalid;
      next_bresp   = s_bresp;
      if (s_bvalid && s_bready) begin
         next_bvalid = 1'b0;
      end
      if (s_awvalid && s_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_awaddr;
      end
      if (s_wvalid && s_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_wdata;
         next_w_strb = s_wstrb;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = addr_mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready  = !next_w_held && !next_bvalid;
   end

   always_comb begin
      next_rvalid  = s_rvalid;
      next_rdata   = s_rdata;
      next_rresp   = s_rresp;
      if (s_rvalid && s_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_arvalid && s_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = `RESP_OKAY;
         case (s_araddr)
            `OFS_INPUT_SELECT_HALL: begin
               next_rdata = {24'h000000, input_select_hall};
            end
            `OFS_INPUT_SELECT_SERIAL: begin
               next_rdata = {24'h000000, input_select_serial};
            end
            `OFS_INPUT_SELECT_CAPTURE: begin
               next_rdata = {24'h000000, input_select_capture};
            end
            `OFS_ROUTE_STATUS: begin
               next_rdata = {28'h0000000, periph};
            end
            default: begin
               next_rdata = 32'h00000000;
               next_rresp = `RESP_SLVERR;
            end
         endcase
      end
      next_arready = !next_rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held   <= 1'b0;
         w_held    <= 1'b0;
         aw_addr   <= 4'h0;
         w_data    <= 32'h00000000;
         w_strb    <= 4'h0;
         s_awready <= 1'b0;
         s_wready  <= 1'b0;
         s_bvalid  <= 1'b0;
         s_bresp   <= 2'h0;
         s_arready <= 1'b0;
         s_rvalid  <= 1'b0;
         s_rdata   <= 32'h00000000;
         s_rresp   <= 2'h0;
      end else if (ce) begin
         aw_held   <= next_aw_held;
         w_held    <= next_w_held;
         aw_addr   <= next_aw_addr;
         w_data    <= next_w_data;
         w_strb    <= next_w_strb;
         s_awready <= next_awready;
         s_wready  <= next_wready;
         s_bvalid  <= next_bvalid;
         s_bresp   <= next_bresp;
         s_arready <= next_arready;
         s_rvalid  <= next_rvalid;
         s_rdata   <= next_rdata;
         s_rresp   <= next_rresp;
      end
   end

   select_reg #(
      .RESET_VALUE (`RST_INPUT_SELECT_HALL)
   ) u_reg_hall (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .wr_en   (wr_hall),
      .wr_data (w_data),
      .wr_strb (w_strb),
      .value   (input_select_hall)
   );

   select_reg #(
      .RESET_VALUE (`RST_INPUT_SELECT_SERIAL)
   ) u_reg_serial (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .wr_en   (wr_serial),
      .wr_data (w_data),
      .wr_strb (w_strb),
      .value   (input_select_serial)
   );

   // Bits 3:2 are stored as written; software is expected to leave them at 00.
   select_reg #(
      .RESET_VALUE (`RST_INPUT_SELECT_CAPTURE)
   ) u_reg_capture (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .wr_en   (wr_capture),
      .wr_data (w_data),
      .wr_strb (w_strb),
      .value   (input_select_capture)
   );

   src_route #(.ALIAS_OK(1'b1)) u_route_hall (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .field   (input_select_hall[`POS_HALL_SRC_FIELD +: 2]),
      .pin     (pins.port_a_bit3),
      .routed  (periph.hall_sensor_input_one)
   );

   src_route #(.ALIAS_OK(1'b1)) u_route_cap0 (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .field   (input_select_capture[`POS_CAP0_SRC_FIELD +: 2]),
      .pin     (pins.port_a_bit0),
      .routed  (periph.timer0_capture_in)
   );

   src_route #(.ALIAS_OK(1'b0)) u_route_cap1 (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .field   (input_select_capture[`POS_CAP1_SRC_FIELD +: 2]),
      .pin     (pins.port_a_bit2),
      .routed  (periph.timer1_capture_in)
   );

   src_route #(.ALIAS_OK(1'b1)) u_route_cap3 (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .field   (input_select_capture[`POS_CAP3_SRC_FIELD +: 2]),
      .pin     (pins.port_b_bit1),
      .routed  (periph.timer3_capture_in)
   );

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic [1:0] hall_f;
   logic [1:0] cap0_f;
   logic [1:0] cap1_f;
   logic [1:0] cap3_f;
   assign hall_f = input_select_hall[`POS_HALL_SRC_FIELD +: 2];
   assign cap0_f = input_select_capture[`POS_CAP0_SRC_FIELD +: 2];
   assign cap1_f = input_select_capture[`POS_CAP1_SRC_FIELD +: 2];
   assign cap3_f = input_select_capture[`POS_CAP3_SRC_FIELD +: 2];

   sequence hall_code_valid;
      ce && (hall_f == 2'h0 || hall_f == 2'h3);
   endsequence

   sequence capture_write_done;
      ce && wr_capture ##1 ce[*1];
   endsequence

   chk_hall_routing: assert property (hall_code_valid |=> periph.hall_sensor_input_one == $past(pins.port_a_bit3))
      else $error("Hall input does not follow port A bit 3.");

   chk_cap0_routing: assert property (ce && (cap0_f == 2'h0 || cap0_f == 2'h3)
                                      |=> periph.timer0_capture_in == $past(pins.port_a_bit0))
      else $error("Timer 0 capture does not follow port A bit 0.");

   chk_cap1_routing: assert property (ce && cap1_f == 2'h0
                                      |=> periph.timer1_capture_in == $past(pins.port_a_bit2))
      else $error("Timer 1 capture does not follow port A bit 2.");

   chk_cap3_routing: assert property (ce && (cap3_f == 2'h0 || cap3_f == 2'h3)
                                      |=> periph.timer3_capture_in == $past(pins.port_b_bit1))
      else $error("Timer 3 capture does not follow port B bit 1.");

   chk_hall_parked: assert property (ce && (hall_f == 2'h1 || hall_f == 2'h2)
                                     |=> periph.hall_sensor_input_one == `INACTIVE_LEVEL)
      else $error("Hall input not parked on a reserved code.");

   chk_cap1_parked: assert property (ce && cap1_f != 2'h0 |=> !periph.timer1_capture_in)
      else $error("Timer 1 capture not parked on a non-selecting code.");

   chk_cap0_parked: assert property (ce && (cap0_f == 2'h1 || cap0_f == 2'h2) |=> !periph.timer0_capture_in)
      else $error("Timer 0 capture not parked on a reserved code.");

   chk_cap3_parked: assert property (ce && (cap3_f == 2'h1 || cap3_f == 2'h2) |=> !periph.timer3_capture_in)
      else $error("Timer 3 capture not parked on a reserved code.");

   chk_capture_write: assert property (capture_write_done |-> input_select_capture == $past(w_data[7:0], 1)
                                       || !$past(w_strb[0], 1))
      else $error("Capture selection register did not take the written byte.");

   chk_resp_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
      else $error("Write response dropped before it was taken.");

endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the input source selection block.
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import pin_select_pkg::*;

   logic           aclk      = 1'h0;
   logic           aresetn   = 1'h0;
   logic           ce        = 1'h1;
   logic [3:0]     s_awaddr  = 4'h0;
   logic [3:0]     s_wstrb   = 4'h0;
   logic [3:0]     s_araddr  = 4'h0;
   logic [31:0]    s_wdata   = 32'h0;
   logic           s_awvalid = 1'h0;
   logic           s_wvalid  = 1'h0;
   logic           s_bready  = 1'h0;
   logic           s_arvalid = 1'h0;
   logic           s_rready  = 1'h0;
   logic           s_awready;
   logic           s_wready;
   logic           s_bvalid;
   logic           s_arready;
   logic           s_rvalid;
   logic [1:0]     s_bresp;
   logic [1:0]     s_rresp;
   logic [31:0]    s_rdata;
   port_pins_t     pins      = '0;
   peripheral_in_t periph;
   int             miscompares = 0;
   int             comparisons = 0;

   input_source_pin_select u_input_source_pin_select (
      .aclk, .aresetn, .ce,
      .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
      .s_bresp, .s_bvalid, .s_bready,
      .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
      .pins, .periph
   );

   always #50 aclk = ~aclk;

   task automatic give_verdict;
      $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_route(input string what, input logic [3:0] exp, input logic [3:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Every bus wait passes through here so a silent slave ends the run.
   task automatic tick(inout int n);
      @(posedge aclk);
      n++;
      if (n > 40) begin
         miscompares++;
         $display("BAD bus answer expected within 40 cycles seen none");
         give_verdict();
      end
   endtask

   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] r);
      int   n;
      logic aw;
      logic w;
      n = 0;
      aw = 1'h1;
      w = 1'h1;
      s_awaddr <= a;
      s_wdata <= d;
      s_wstrb <= s;
      s_awvalid <= 1'h1;
      s_wvalid <= 1'h1;
      s_bready <= 1'h1;
      while (aw || w) begin
         tick(n);
         if (aw && s_awready) begin
            aw = 1'h0;
            s_awvalid <= 1'h0;
         end
         if (w && s_wready) begin
            w = 1'h0;
            s_wvalid <= 1'h0;
         end
      end
      do tick(n); while (!s_bvalid);
      r = s_bresp;
      s_bready <= 1'h0;
      tick(n);
   endtask

   task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      s_araddr <= a;
      s_arvalid <= 1'h1;
      s_rready <= 1'h1;
      do tick(n); while (!s_arready);
      s_arvalid <= 1'h0;
      do tick(n); while (!s_rvalid);
      d = s_rdata;
      r = s_rresp;
      s_rready <= 1'h0;
      tick(n);
   endtask

   task automatic check_reset;
      logic [31:0] d;
      logic [1:0]  r;
      for (int i = 0; i < 4; i++) begin
         axi_read(4'(i * 4), d, r);
         cmp_word("reset value", 32'h0, d);
         cmp_resp("reset read resp", 2'h0, r);
      end
   endtask

   // Walks every code through all four fields and checks which pin reaches which input.
   task automatic check_routing;
      logic [31:0] d;
      logic [1:0]  r;
      logic [3:0]  mask;
      logic [3:0]  pat;
      logic        sel;
      for (int c = 0; c < 4; c++) begin
         sel = (c == 0) || (c == 3);
         mask = {sel, c == 0, sel, sel};
         axi_write(4'h0, 32'(c) << 2, 4'hF, r);
         cmp_resp("hall write resp", 2'h0, r);
         axi_write(4'h8, {24'h0, 2'(c), 2'(c), 2'h0, 2'(c)}, 4'hF, r);
         axi_read(4'h8, d, r);
         cmp_word("capture readback", {24'h0, 2'(c), 2'(c), 2'h0, 2'(c)}, d);
         for (int p = 0; p < 2; p++) begin
            pat = p ? 4'hA : 4'h5;
            pins <= pat;
            @(posedge aclk);
            @(posedge aclk);
            cmp_route("periph", mask & pat, periph);
            axi_read(4'hC, d, r);
            cmp_word("route status", {28'h0, mask & pat}, d);
         end
      end
   endtask

   task automatic check_refusals;
      logic [31:0] d;
      logic [1:0]  r;
      axi_write(4'h6, 32'h0000_00FF, 4'hF, r);
      cmp_resp("unmapped write resp", 2'h2, r);
      axi_read(4'h6, d, r);
      cmp_resp("unmapped read resp", 2'h2, r);
      cmp_word("unmapped read data", 32'h0, d);
      axi_write(4'h0, 32'h0000_0000, 4'hE, r);
      cmp_resp("masked write resp", 2'h0, r);
      axi_read(4'h0, d, r);
      cmp_word("hall after masked write", 32'h0000_000C, d);
      axi_write(4'h4, 32'hFFFF_FF5A, 4'hF, r);
      axi_read(4'h4, d, r);
      cmp_word("serial readback", 32'h0000_005A, d);
      axi_write(4'hC, 32'h0000_000F, 4'hF, r);
      cmp_resp("status write resp", 2'h0, r);
      axi_read(4'hC, d, r);
      cmp_word("status after write", 32'h0000_000A, d);
   endtask

   // With every field at the alias code, a low clock enable must hold the routed inputs.
   task automatic check_freeze;
      ce <= 1'h0;
      pins <= 4'hF;
      @(posedge aclk);
      @(posedge aclk);
      cmp_route("periph frozen", 4'hA, periph);
      ce <= 1'h1;
      @(posedge aclk);
      @(posedge aclk);
      cmp_route("periph after enable", 4'hB, periph);
   endtask

   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      check_reset();
      check_routing();
      check_refusals();
      check_freeze();
      give_verdict();
   end
endmodule
